//--- hw/wcd_pkg.sv
package wcd_pkg;

  typedef enum logic [4:0] {
    WCD_OP_NONE = 5'h00,
    WCD_OP_BYTE_SUM = 5'h01,
    WCD_OP_BYTE_COMPARE = 5'h02,
    WCD_OP_IMMEDIATE_COMPARE = 5'h03,
    WCD_OP_IRQ_MASK_LOAD = 5'h04,
    WCD_OP_REGFILE_BASE_LOAD = 5'h05,
    WCD_OP_BYTE_DIFFERENCE = 5'h06,
    WCD_OP_ROTATE_RIGHT = 5'h07,
    WCD_OP_LOGICAL_RIGHT = 5'h08,
    WCD_OP_ARITH_LEFT = 5'h09,
    WCD_OP_ARITH_RIGHT = 5'h0A,
    WCD_OP_BYTE_BIT_CLEAR = 5'h0B,
    WCD_OP_MAGNITUDE = 5'h0C,
    WCD_OP_CONTEXT_BRANCH = 5'h0D,
    WCD_OP_ONES_COMPLEMENT = 5'h0E,
    WCD_OP_TWOS_COMPLEMENT = 5'h0F,
    WCD_OP_BRANCH_HIGH_EQUAL = 5'h10,
    WCD_OP_BRANCH_GREATER = 5'h11,
    WCD_OP_BRANCH_LOW_EQUAL = 5'h12,
    WCD_OP_IMMEDIATE_OR = 5'h13,
    WCD_OP_EXTERNAL_ROM_EXEC = 5'h14
  } wcd_op_t;

  typedef enum logic [1:0] {
    WCD_ST_IDLE = 2'b00,
    WCD_ST_IMM = 2'b01
  } wcd_state_t;

  // Top nibble classes
  localparam logic [3:0] WCD_TOP_BYTE_SUM = 4'hB;
  localparam logic [3:0] WCD_TOP_BYTE_COMPARE = 4'h9;
  localparam logic [3:0] WCD_TOP_BYTE_DIFFERENCE = 4'h7;
  localparam logic [3:0] WCD_TOP_BYTE_BIT_CLEAR = 4'h5;
  // High byte of jump words
  localparam logic [7:0] WCD_HI_BRANCH_HIGH_EQUAL = 8'h14;
  localparam logic [7:0] WCD_HI_BRANCH_GREATER = 8'h15;
  localparam logic [7:0] WCD_HI_BRANCH_LOW_EQUAL = 8'h12;
  // High byte of shift words
  localparam logic [7:0] WCD_HI_ARITH_RIGHT = 8'h08;
  localparam logic [7:0] WCD_HI_LOGICAL_RIGHT = 8'h09;
  localparam logic [7:0] WCD_HI_ARITH_LEFT = 8'h0A;
  localparam logic [7:0] WCD_HI_ROTATE_RIGHT = 8'h0B;
  // Upper twelve bits of one-register words
  localparam logic [11:0] WCD_U12_IMMEDIATE_OR = 12'h026;
  localparam logic [11:0] WCD_U12_IMMEDIATE_COMPARE = 12'h028;
  localparam logic [11:0] WCD_U12_CONTEXT_BRANCH = 12'h041;
  localparam logic [11:0] WCD_U12_TWOS_COMPLEMENT = 12'h050;
  localparam logic [11:0] WCD_U12_ONES_COMPLEMENT = 12'h054;
  localparam logic [11:0] WCD_U12_MAGNITUDE = 12'h074;
  // Fixed words
  localparam logic [15:0] WCD_W_REGFILE_BASE_LOAD = 16'h02E0;
  localparam logic [15:0] WCD_W_IRQ_MASK_LOAD = 16'h0300;
  localparam logic [15:0] WCD_W_EXTERNAL_ROM_EXEC = 16'h03E0;

  // Field positions
  localparam int WCD_TOP_MSB = 15;
  localparam int WCD_TOP_LSB = 12;
  localparam int WCD_HI_MSB = 15;
  localparam int WCD_HI_LSB = 8;
  localparam int WCD_U12_LSB = 4;
  localparam int WCD_DMODE_MSB = 11;
  localparam int WCD_DMODE_LSB = 10;
  localparam int WCD_DREG_MSB = 9;
  localparam int WCD_DREG_LSB = 6;
  localparam int WCD_SMODE_MSB = 5;
  localparam int WCD_SMODE_LSB = 4;
  localparam int WCD_SREG_MSB = 3;
  localparam int WCD_SREG_LSB = 0;
  localparam int WCD_CNT_MSB = 7;
  localparam int WCD_CNT_LSB = 4;
  localparam int WCD_DISP_MSB = 7;
  localparam int WCD_SIGN_BIT = 15;

  localparam logic [3:0] WCD_CNT_FROM_R0 = 4'h0;
  localparam logic [15:0] WCD_WORD_RESET = 16'h0000;
  localparam logic [15:0] WCD_PC_STEP = 16'h0002;

endpackage : wcd_pkg

//--- hw/wcd_shifter.sv
`timescale 1ns/1ps
module wcd_shifter
  import wcd_pkg::*;
(
  // Operand and control
  input wire logic [15:0] value,
  input wire logic [3:0] count,
  input wire wcd_pkg::wcd_op_t op,
  // Result
  output logic [15:0] result,
  output logic carry
);
  logic [31:0] dbl;

  always_comb begin
    dbl = 32'h00000000;
    result = value;
    carry = 1'b0;
    case (op)
      WCD_OP_ROTATE_RIGHT: begin
        dbl = {value, value} >> count;
        result = dbl[15:0];
        carry = result[WCD_SIGN_BIT];
      end
      WCD_OP_LOGICAL_RIGHT: begin
        dbl = {value, 16'h0000} >> count;
        result = dbl[31:16];
        carry = dbl[15];
      end
      WCD_OP_ARITH_RIGHT: begin
        dbl = 32'($signed({value, 16'h0000}) >>> count);
        result = dbl[31:16];
        carry = dbl[15];
      end
      WCD_OP_ARITH_LEFT: begin
        dbl = {16'h0000, value} << count;
        result = dbl[15:0];
        carry = dbl[16];
      end
      default: begin
        result = value;
        carry = 1'b0;
      end
    endcase
  end
endmodule : wcd_shifter

//--- hw/wcd_decoder.sv
`timescale 1ns/1ps
// Contract
// - Bxxx decodes as byte add of source into destination.
// - 9xxx decodes as byte compare, status only, no write.
// - 028s compares register s with immediate from next word.
// - Fixed word 0300 loads interrupt mask from immediate.
// - Fixed word 02E0 loads register-file base from next word.
// - 7xxx decodes as byte subtract, result to destination.
// - 0Bns rotates register s right circularly by n.
// - 09ns shifts register s right logically by n.
// - 0Ans shifts register s left arithmetically by n.
// - 5xxx clears destination byte bits set in source.
// - 074s replaces register s with its absolute value.
// - 041s context branch, operand indirect through register s.
// - 054s inverts register s (ones complement).
// - 050s negates register s (twos complement).
// - 14yy jumps if unsigned high or equal.
// - 15yy jumps if signed greater than.
// - 12yy jumps if low or equal.
// - 026s ORs register s with next word, writes back.
// - Fixed word 03E0 signals external load-ROM-and-execute.
// - Zero shift count takes low four bits of register zero.
// - Rotation feeds bits leaving bit 0 back into the top.
// - Arithmetic right shift fills with the original sign bit.
module wcd_decoder
  import wcd_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Fetch side
  input wire logic fetch_valid,
  input wire logic [15:0] fetch_word,
  input wire logic [15:0] fetch_pc,
  output logic fetch_ready,
  // Execution side operand inputs
  input wire logic [15:0] reg_zero,
  input wire logic [15:0] shift_value,
  // Decoded instruction
  output logic dec_valid,
  input wire logic dec_ready,
  output wcd_pkg::wcd_op_t dec_op,
  output logic [1:0] dest_mode,
  output logic [3:0] dest_register,
  output logic [1:0] source_mode,
  output logic [3:0] source_register,
  output logic [3:0] shift_count,
  output logic [15:0] immediate,
  output logic [15:0] jump_target,
  output logic byte_op,
  output logic writes_dest,
  output logic ext_rom_exec,
  // Shift unit result for decoded shifts
  output logic [15:0] shift_result,
  output logic shift_carry
);

  wcd_state_t state_r;
  wcd_op_t op_nxt;
  logic needs_imm;
  logic is_shift;
  logic take;
  logic take_imm;
  logic [3:0] cnt_field;
  logic [15:0] disp_words;
  logic [3:0] top;
  logic [7:0] hi;
  logic [11:0] u12;

  assign top = fetch_word[WCD_TOP_MSB:WCD_TOP_LSB];
  assign hi = fetch_word[WCD_HI_MSB:WCD_HI_LSB];
  assign u12 = fetch_word[WCD_HI_MSB:WCD_U12_LSB];
  assign cnt_field = fetch_word[WCD_CNT_MSB:WCD_CNT_LSB];

  // Opcode recognition, fixed words before prefixes
  always_comb begin
    op_nxt = WCD_OP_NONE;
    if (fetch_word == WCD_W_IRQ_MASK_LOAD) begin
      op_nxt = WCD_OP_IRQ_MASK_LOAD;
    end else if (fetch_word == WCD_W_REGFILE_BASE_LOAD) begin
      op_nxt = WCD_OP_REGFILE_BASE_LOAD;
    end else if (fetch_word == WCD_W_EXTERNAL_ROM_EXEC) begin
      op_nxt = WCD_OP_EXTERNAL_ROM_EXEC;
    end else if (top == WCD_TOP_BYTE_SUM) begin
      op_nxt = WCD_OP_BYTE_SUM;
    end else if (top == WCD_TOP_BYTE_COMPARE) begin
      op_nxt = WCD_OP_BYTE_COMPARE;
    end else if (top == WCD_TOP_BYTE_DIFFERENCE) begin
      op_nxt = WCD_OP_BYTE_DIFFERENCE;
    end else if (top == WCD_TOP_BYTE_BIT_CLEAR) begin
      op_nxt = WCD_OP_BYTE_BIT_CLEAR;
    end else if (hi == WCD_HI_ROTATE_RIGHT) begin
      op_nxt = WCD_OP_ROTATE_RIGHT;
    end else if (hi == WCD_HI_LOGICAL_RIGHT) begin
      op_nxt = WCD_OP_LOGICAL_RIGHT;
    end else if (hi == WCD_HI_ARITH_LEFT) begin
      op_nxt = WCD_OP_ARITH_LEFT;
    end else if (hi == WCD_HI_ARITH_RIGHT) begin
      op_nxt = WCD_OP_ARITH_RIGHT;
    end else if (hi == WCD_HI_BRANCH_HIGH_EQUAL) begin
      op_nxt = WCD_OP_BRANCH_HIGH_EQUAL;
    end else if (hi == WCD_HI_BRANCH_GREATER) begin
      op_nxt = WCD_OP_BRANCH_GREATER;
    end else if (hi == WCD_HI_BRANCH_LOW_EQUAL) begin
      op_nxt = WCD_OP_BRANCH_LOW_EQUAL;
    end else if (u12 == WCD_U12_IMMEDIATE_COMPARE) begin
      op_nxt = WCD_OP_IMMEDIATE_COMPARE;
    end else if (u12 == WCD_U12_IMMEDIATE_OR) begin
      op_nxt = WCD_OP_IMMEDIATE_OR;
    end else if (u12 == WCD_U12_MAGNITUDE) begin
      op_nxt = WCD_OP_MAGNITUDE;
    end else if (u12 == WCD_U12_CONTEXT_BRANCH) begin
      op_nxt = WCD_OP_CONTEXT_BRANCH;
    end else if (u12 == WCD_U12_ONES_COMPLEMENT) begin
      op_nxt = WCD_OP_ONES_COMPLEMENT;
    end else if (u12 == WCD_U12_TWOS_COMPLEMENT) begin
      op_nxt = WCD_OP_TWOS_COMPLEMENT;
    end
  end

  assign needs_imm = (op_nxt == WCD_OP_IMMEDIATE_COMPARE) || (op_nxt == WCD_OP_IMMEDIATE_OR) ||
                     (op_nxt == WCD_OP_IRQ_MASK_LOAD) || (op_nxt == WCD_OP_REGFILE_BASE_LOAD);
  assign is_shift = (op_nxt == WCD_OP_ROTATE_RIGHT) || (op_nxt == WCD_OP_LOGICAL_RIGHT) ||
                    (op_nxt == WCD_OP_ARITH_LEFT) || (op_nxt == WCD_OP_ARITH_RIGHT);

  // Output slot holds one instruction; a new word only enters once it drains
  assign fetch_ready = (state_r == WCD_ST_IMM) || !dec_valid || dec_ready;
  assign take = fetch_valid && fetch_ready && (state_r == WCD_ST_IDLE);
  assign take_imm = fetch_valid && (state_r == WCD_ST_IMM);

  // Word displacement doubled into bytes
  assign disp_words = {{7{fetch_word[WCD_DISP_MSB]}}, fetch_word[WCD_DISP_MSB:0], 1'b0};

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_r <= WCD_ST_IDLE;
    end else begin
      case (state_r)
        WCD_ST_IDLE: begin
          if (take && needs_imm) begin
            state_r <= WCD_ST_IMM;
          end
        end
        WCD_ST_IMM: begin
          if (take_imm) begin
            state_r <= WCD_ST_IDLE;
          end
        end
        default: begin
          state_r <= WCD_ST_IDLE;
        end
      endcase
    end
  end

  // Valid rises once the whole instruction, immediate included, is held
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      dec_valid <= 1'b0;
    end else if (take_imm) begin
      dec_valid <= 1'b1;
    end else if (take) begin
      dec_valid <= !needs_imm;
    end else if (dec_ready) begin
      dec_valid <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      immediate <= WCD_WORD_RESET;
    end else if (take_imm) begin
      immediate <= fetch_word;
    end else if (take) begin
      immediate <= WCD_WORD_RESET;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      dec_op <= WCD_OP_NONE;
      dest_mode <= 2'b00;
      dest_register <= 4'h0;
      source_mode <= 2'b00;
      source_register <= 4'h0;
      byte_op <= 1'b0;
      writes_dest <= 1'b0;
      ext_rom_exec <= 1'b0;
    end else if (take) begin
      dec_op <= op_nxt;
      dest_mode <= fetch_word[WCD_DMODE_MSB:WCD_DMODE_LSB];
      dest_register <= fetch_word[WCD_DREG_MSB:WCD_DREG_LSB];
      source_mode <= fetch_word[WCD_SMODE_MSB:WCD_SMODE_LSB];
      source_register <= fetch_word[WCD_SREG_MSB:WCD_SREG_LSB];
      byte_op <= (op_nxt == WCD_OP_BYTE_SUM) || (op_nxt == WCD_OP_BYTE_COMPARE) ||
                 (op_nxt == WCD_OP_BYTE_DIFFERENCE) || (op_nxt == WCD_OP_BYTE_BIT_CLEAR);
      // Compares only touch status
      writes_dest <= (op_nxt == WCD_OP_BYTE_SUM) || (op_nxt == WCD_OP_BYTE_DIFFERENCE) ||
                     (op_nxt == WCD_OP_BYTE_BIT_CLEAR) || (op_nxt == WCD_OP_IMMEDIATE_OR) ||
                     (op_nxt == WCD_OP_MAGNITUDE) || (op_nxt == WCD_OP_ONES_COMPLEMENT) ||
                     (op_nxt == WCD_OP_TWOS_COMPLEMENT) || is_shift;
      ext_rom_exec <= (op_nxt == WCD_OP_EXTERNAL_ROM_EXEC);
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      shift_count <= 4'h0;
    end else if (take) begin
      // Zero field means count comes from register zero
      if (cnt_field == WCD_CNT_FROM_R0) begin
        shift_count <= reg_zero[3:0];
      end else begin
        shift_count <= cnt_field;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      jump_target <= WCD_WORD_RESET;
    end else if (take) begin
      jump_target <= 16'(fetch_pc + WCD_PC_STEP + disp_words);
    end
  end

  // Shift datapath works on the held operand from the register file
  wcd_shifter u_shifter (
    .value(shift_value),
    .count(shift_count),
    .op(dec_op),
    .result(shift_result),
    .carry(shift_carry)
  );

  property p_byte_sum;
    @(posedge clock) disable iff (!resetn)
    (take && fetch_word[15:12] == 4'hB) |=> (dec_op == WCD_OP_BYTE_SUM && byte_op && writes_dest);
  endproperty
  a_byte_sum: assert property (p_byte_sum) else $error("byte add not decoded");

  property p_byte_compare;
    @(posedge clock) disable iff (!resetn)
    (take && fetch_word[15:12] == 4'h9) |=> (dec_op == WCD_OP_BYTE_COMPARE && !writes_dest);
  endproperty
  a_byte_compare: assert property (p_byte_compare) else $error("byte compare writes");

  property p_imm_compare;
    @(posedge clock) disable iff (!resetn)
    (take && fetch_word[15:4] == 12'h028) |=> (!dec_valid && state_r == WCD_ST_IMM);
  endproperty
  a_imm_compare: assert property (p_imm_compare) else $error("compare immediate not awaited");

  property p_irq_mask;
    @(posedge clock) disable iff (!resetn)
    (take && fetch_word == 16'h0300) |=> (dec_op == WCD_OP_IRQ_MASK_LOAD);
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("mask load not decoded");

  property p_base_load;
    @(posedge clock) disable iff (!resetn)
    (state_r == WCD_ST_IMM && fetch_valid) |=> (dec_valid && immediate == $past(fetch_word));
  endproperty
  a_base_load: assert property (p_base_load) else $error("immediate word not captured");

  property p_rotate;
    @(posedge clock) disable iff (!resetn)
    (dec_op == WCD_OP_ROTATE_RIGHT && shift_count == 4'h1) |->
      (shift_result == {shift_value[0], shift_value[15:1]});
  endproperty
  a_rotate: assert property (p_rotate) else $error("rotate by one wrong");

  property p_arith_right;
    @(posedge clock) disable iff (!resetn)
    (dec_op == WCD_OP_ARITH_RIGHT && shift_count == 4'h1) |->
      (shift_result == {shift_value[15], shift_value[15:1]});
  endproperty
  a_arith_right: assert property (p_arith_right) else $error("sign fill wrong");

  property p_zero_count;
    @(posedge clock) disable iff (!resetn)
    (take && fetch_word[15:8] == 8'h09 && fetch_word[7:4] == 4'h0) |=>
      (shift_count == $past(reg_zero[3:0]));
  endproperty
  a_zero_count: assert property (p_zero_count) else $error("zero count not from register zero");

  property p_jump;
    @(posedge clock) disable iff (!resetn)
    (take && fetch_word[15:8] == 8'h14) |=>
      (dec_op == WCD_OP_BRANCH_HIGH_EQUAL &&
       jump_target == 16'($past(fetch_pc) + 16'h0002 + {{7{$past(fetch_word[7])}}, $past(fetch_word[7:0]), 1'b0}));
  endproperty
  a_jump: assert property (p_jump) else $error("jump target wrong");

  property p_byte_diff;
    @(posedge clock) disable iff (!resetn)
    (take && fetch_word[15:12] == 4'h7) |=> (dec_op == WCD_OP_BYTE_DIFFERENCE && byte_op && writes_dest);
  endproperty
  a_byte_diff: assert property (p_byte_diff) else $error("byte subtract not decoded");

  property p_bit_clear;
    @(posedge clock) disable iff (!resetn)
    (take && fetch_word[15:12] == 4'h5) |=> (dec_op == WCD_OP_BYTE_BIT_CLEAR && byte_op && writes_dest);
  endproperty
  a_bit_clear: assert property (p_bit_clear) else $error("byte bit clear not decoded");

  property p_rotate_dec;
    @(posedge clock) disable iff (!resetn)
    (take && fetch_word[15:8] == 8'h0B) |=> (dec_op == WCD_OP_ROTATE_RIGHT && writes_dest);
  endproperty
  a_rotate_dec: assert property (p_rotate_dec) else $error("rotate not decoded");

  property p_logical_dec;
    @(posedge clock) disable iff (!resetn)
    (take && fetch_word[15:8] == 8'h09) |=> (dec_op == WCD_OP_LOGICAL_RIGHT && writes_dest);
  endproperty
  a_logical_dec: assert property (p_logical_dec) else $error("logical shift not decoded");

  property p_arith_left_dec;
    @(posedge clock) disable iff (!resetn)
    (take && fetch_word[15:8] == 8'h0A && fetch_word[7:4] != 4'h0) |=>
      (dec_op == WCD_OP_ARITH_LEFT && shift_count == $past(fetch_word[7:4]));
  endproperty
  a_arith_left_dec: assert property (p_arith_left_dec) else $error("left shift not decoded");

  property p_magnitude;
    @(posedge clock) disable iff (!resetn)
    (take && fetch_word[15:4] == 12'h074) |=> (dec_op == WCD_OP_MAGNITUDE && writes_dest);
  endproperty
  a_magnitude: assert property (p_magnitude) else $error("absolute value not decoded");

  property p_context_branch;
    @(posedge clock) disable iff (!resetn)
    (take && fetch_word[15:4] == 12'h041) |=> (dec_op == WCD_OP_CONTEXT_BRANCH && !writes_dest);
  endproperty
  a_context_branch: assert property (p_context_branch) else $error("context branch not decoded");

  property p_invert;
    @(posedge clock) disable iff (!resetn)
    (take && fetch_word[15:4] == 12'h054) |=> (dec_op == WCD_OP_ONES_COMPLEMENT && writes_dest);
  endproperty
  a_invert: assert property (p_invert) else $error("invert not decoded");

  property p_negate;
    @(posedge clock) disable iff (!resetn)
    (take && fetch_word[15:4] == 12'h050) |=> (dec_op == WCD_OP_TWOS_COMPLEMENT && writes_dest);
  endproperty
  a_negate: assert property (p_negate) else $error("negate not decoded");

  property p_ext_rom;
    @(posedge clock) disable iff (!resetn)
    (take && fetch_word == 16'h03E0) |=> (dec_op == WCD_OP_EXTERNAL_ROM_EXEC && ext_rom_exec && dec_valid);
  endproperty
  a_ext_rom: assert property (p_ext_rom) else $error("external control not flagged");

endmodule : wcd_decoder

//--- dv/wcd_fetch_model.sv
`timescale 1ns/1ps
module wcd_fetch_model
  import wcd_pkg::*;
(
  // Clock
  input wire logic clock,
  // Handshake from decoder
  input wire logic fetch_ready,
  // Word offered to decoder
  output logic fetch_valid,
  output logic [15:0] fetch_word,
  output logic [15:0] fetch_pc
);
  import wcd_pkg::*;
  logic [15:0] prog [0:15];

  initial begin
    fetch_valid = 1'b0;
    fetch_word = 16'h0000;
    fetch_pc = 16'h0000;
  end

  // Caller enters just after a rising edge; each word held until taken
  task automatic play(input int n, input logic [15:0] pc0);
    for (int i = 0; i < n; i++) begin
      fetch_valid = 1'b1;
      fetch_word = prog[i];
      fetch_pc = pc0 + 16'(2 * i);
      do @(posedge clock); while (fetch_ready !== 1'b1);
      #1;
    end
    fetch_valid = 1'b0;
    // Released bus shows inverted data so a stale word cannot pass
    fetch_word = ~fetch_word;
    fetch_pc = ~fetch_pc;
  endtask : play
endmodule : wcd_fetch_model

//--- dv/tb_word_cpu_opcode_decoder.sv
`timescale 1ns/1ps
module tb_word_cpu_opcode_decoder;
  import wcd_pkg::*;
  typedef struct packed {
    wcd_op_t op;
    logic [1:0] dm;
    logic [3:0] dr;
    logic [1:0] sm;
    logic [3:0] sr;
    logic [3:0] cnt;
    logic [15:0] imm;
    logic [15:0] jt;
    logic [2:0] flg;
    logic [15:0] sres;
    logic sc;
  } wcd_obs_t;
  logic clock, resetn, fetch_valid, fetch_ready, dec_valid, dec_ready;
  logic byte_op, writes_dest, ext_rom_exec, shift_carry;
  logic [15:0] fetch_word, fetch_pc, reg_zero, shift_value, immediate, jump_target, shift_result;
  logic [1:0] dest_mode, source_mode;
  logic [3:0] dest_register, source_register, shift_count;
  wcd_op_t dec_op;
  int n_mismatch, n_tests;
  wcd_obs_t obs_q[$];
  logic [15:0] pc0;

  wcd_decoder DUT (.clock, .resetn, .fetch_valid, .fetch_word, .fetch_pc, .fetch_ready, .reg_zero,
    .shift_value, .dec_valid, .dec_ready, .dec_op, .dest_mode, .dest_register, .source_mode,
    .source_register, .shift_count, .immediate, .jump_target, .byte_op, .writes_dest, .ext_rom_exec,
    .shift_result, .shift_carry);
  wcd_fetch_model u_fetch (.clock, .fetch_ready, .fetch_valid, .fetch_word, .fetch_pc);

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // Every accepted decode is logged with pre-edge values
  always @(posedge clock) begin
    if (dec_valid === 1'b1 && dec_ready === 1'b1) begin
      obs_q.push_back('{dec_op, dest_mode, dest_register, source_mode, source_register, shift_count,
        immediate, jump_target, {byte_op, writes_dest, ext_rom_exec}, shift_result, shift_carry});
    end
  end

  task automatic chk_op(input wcd_op_t exp, input wcd_op_t got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t op exp %s got %s", $time, exp.name(), got.name());
    end
  endtask : chk_op

  task automatic chk_bits(input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t value exp %h got %h", $time, exp, got);
    end
  endtask : chk_bits

  function automatic wcd_obs_t pop_obs();
    if (obs_q.size() == 0) return 'x;
    return obs_q.pop_front();
  endfunction : pop_obs

  function automatic logic [16:0] exp_shift(input wcd_op_t op, input logic [15:0] v, input int n);
    logic [31:0] d;
    d = {v, v};
    case (op)
      WCD_OP_ROTATE_RIGHT: return {d[n + 15], d[n +: 16]};
      WCD_OP_LOGICAL_RIGHT: return {v[n - 1], v >> n};
      WCD_OP_ARITH_LEFT: return {v[16 - n], v << n};
      default: return {v[n - 1], 16'($signed(v) >>> n)};
    endcase
  endfunction : exp_shift

  task automatic run(input int n_words, input int n_dec);
    obs_q.delete();
    u_fetch.play(n_words, pc0);
    for (int i = 0; i < 20 && obs_q.size() < n_dec; i++) @(posedge clock);
    #1;
    chk_bits(16'(n_dec), 16'(obs_q.size()));
  endtask : run

  task automatic t_two_operand();
    logic [15:0] w [4] = '{16'hB123, 16'h95AC, 16'h7FE1, 16'h5ABC};
    wcd_op_t e [4] = '{WCD_OP_BYTE_SUM, WCD_OP_BYTE_COMPARE, WCD_OP_BYTE_DIFFERENCE, WCD_OP_BYTE_BIT_CLEAR};
    wcd_obs_t o;
    for (int i = 0; i < 4; i++) u_fetch.prog[i] = w[i];
    run(4, 4);
    for (int i = 0; i < 4; i++) begin
      o = pop_obs();
      chk_op(e[i], o.op);
      chk_bits({4'h0, w[i][11:0]}, {4'h0, o.dm, o.dr, o.sm, o.sr});
      chk_bits({15'h0, i != 1}, {15'h0, o.flg[1]});
      chk_bits(16'h0001, {15'h0, o.flg[2]});
    end
    $display("test two_operand finished");
  endtask : t_two_operand

  task automatic t_one_register();
    logic [15:0] w [5] = '{16'h0745, 16'h0413, 16'h054A, 16'h050F, 16'h0340};
    wcd_op_t e [5] = '{WCD_OP_MAGNITUDE, WCD_OP_CONTEXT_BRANCH, WCD_OP_ONES_COMPLEMENT,
      WCD_OP_TWOS_COMPLEMENT, WCD_OP_NONE};
    wcd_obs_t o;
    for (int i = 0; i < 5; i++) u_fetch.prog[i] = w[i];
    run(5, 5);
    for (int i = 0; i < 5; i++) begin
      o = pop_obs();
      chk_op(e[i], o.op);
      if (i < 4) chk_bits({12'h000, w[i][3:0]}, {12'h000, o.sr});
    end
    $display("test one_register finished");
  endtask : t_one_register

  task automatic t_immediate();
    logic [15:0] w [9] = '{16'h0285, 16'h1234, 16'h0300, 16'h000F, 16'h02E0, 16'h0080, 16'h0263,
      16'hABCD, 16'h03E0};
    wcd_op_t e [5] = '{WCD_OP_IMMEDIATE_COMPARE, WCD_OP_IRQ_MASK_LOAD, WCD_OP_REGFILE_BASE_LOAD,
      WCD_OP_IMMEDIATE_OR, WCD_OP_EXTERNAL_ROM_EXEC};
    wcd_obs_t o;
    for (int i = 0; i < 9; i++) u_fetch.prog[i] = w[i];
    run(9, 5);
    for (int i = 0; i < 5; i++) begin
      o = pop_obs();
      chk_op(e[i], o.op);
      chk_bits((i < 4) ? w[2 * i + 1] : 16'h0000, o.imm);
      chk_bits({15'h0, i == 4}, {15'h0, o.flg[0]});
      if (i == 0 || i == 3) chk_bits({12'h000, w[2 * i][3:0]}, {12'h000, o.sr});
    end
    $display("test immediate finished");
  endtask : t_immediate

  task automatic t_shifts();
    logic [15:0] w [7] = '{16'h0B35, 16'h0905, 16'h0A75, 16'h0845, 16'h0B05, 16'h0B15, 16'h0815};
    wcd_op_t e [7] = '{WCD_OP_ROTATE_RIGHT, WCD_OP_LOGICAL_RIGHT, WCD_OP_ARITH_LEFT, WCD_OP_ARITH_RIGHT,
      WCD_OP_ROTATE_RIGHT, WCD_OP_ROTATE_RIGHT, WCD_OP_ARITH_RIGHT};
    int n [7] = '{3, 9, 7, 4, 9, 1, 1};
    wcd_obs_t o;
    logic [16:0] x;
    shift_value = 16'h9C35;
    reg_zero = 16'hFFF9;
    for (int i = 0; i < 7; i++) u_fetch.prog[i] = w[i];
    run(7, 7);
    for (int i = 0; i < 7; i++) begin
      o = pop_obs();
      x = exp_shift(e[i], 16'h9C35, n[i]);
      chk_op(e[i], o.op);
      chk_bits(16'(n[i]), {12'h000, o.cnt});
      chk_bits(x[15:0], o.sres);
      chk_bits({15'h0, x[16]}, {15'h0, o.sc});
    end
    $display("test shifts finished");
  endtask : t_shifts

  task automatic t_jumps();
    logic [15:0] w [3] = '{16'h1405, 16'h15FE, 16'h1280};
    wcd_op_t e [3] = '{WCD_OP_BRANCH_HIGH_EQUAL, WCD_OP_BRANCH_GREATER, WCD_OP_BRANCH_LOW_EQUAL};
    wcd_obs_t o;
    pc0 = 16'h0100;
    for (int i = 0; i < 3; i++) u_fetch.prog[i] = w[i];
    run(3, 3);
    for (int i = 0; i < 3; i++) begin
      o = pop_obs();
      chk_op(e[i], o.op);
      chk_bits(pc0 + 16'(2 * i + 2) + {{7{w[i][7]}}, w[i][7:0], 1'b0}, o.jt);
    end
    $display("test jumps finished");
  endtask : t_jumps

  task automatic t_stall();
    wcd_obs_t o;
    dec_ready = 1'b0;
    u_fetch.prog[0] = 16'h0A12;
    u_fetch.prog[1] = 16'h0541;
    obs_q.delete();
    fork
      u_fetch.play(2, pc0);
    join_none
    repeat (4) @(posedge clock);
    #1;
    // Second word must wait while the first decode is unclaimed
    chk_bits(16'h0000, {15'h0, fetch_ready});
    chk_bits(16'h0001, {15'h0, dec_valid});
    chk_op(WCD_OP_ARITH_LEFT, dec_op);
    dec_ready = 1'b1;
    for (int i = 0; i < 20 && obs_q.size() < 2; i++) @(posedge clock);
    #1;
    o = pop_obs();
    chk_op(WCD_OP_ARITH_LEFT, o.op);
    o = pop_obs();
    chk_op(WCD_OP_ONES_COMPLEMENT, o.op);
    $display("test stall finished");
  endtask : t_stall

  task automatic test_done();
    $display("Counts: %0d compared, %0d mismatched", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  // Whole run needs a few dozen cycles; this is far beyond it
  initial begin
    #(40 * 2000);
    n_mismatch++;
    test_done();
  end

  initial begin
    n_mismatch = 0;
    n_tests = 0;
    resetn = 1'b0;
    dec_ready = 1'b1;
    reg_zero = 16'h0000;
    shift_value = 16'h0000;
    pc0 = 16'h0040;
    repeat (3) @(posedge clock);
    #1;
    resetn = 1'b1;
    t_two_operand();
    t_one_register();
    t_immediate();
    t_shifts();
    t_jumps();
    t_stall();
    test_done();
  end
endmodule : tb_word_cpu_opcode_decoder
